// ---- core/tws_pkg.sv ----
// Shared constants for the two-wire register slave and its bus master
// Assumes both ends run from one 100 MHz system clock
`default_nettype none
package tws_pkg;
  // ==========================================================
  // Bus identifiers and device register map
  localparam logic [7:0]  TWS_ID_LOW       = 8'h34;
  localparam logic [7:0]  TWS_ID_HIGH      = 8'h36;
  localparam logic [15:0] TWS_CHIPID_ADDR  = 16'h0000;
  localparam logic [15:0] TWS_PMSTAT_ADDR  = 16'h0002;
  localparam logic [15:0] TWS_CFG_ADDR     = 16'h0101;
  localparam logic [15:0] TWS_PULL_ADDR    = 16'h0721;
  localparam int          TWS_AUTO_INC_BIT = 2;
  localparam int          TWS_PULL_PD_BIT  = 8;
  localparam logic [15:0] TWS_CFG_RST      = 16'h0004;
  localparam logic [15:0] TWS_PULL_RST     = 16'h0100;
  // ==========================================================
  // Host register map over AXI4-Lite
  localparam logic [7:0]  TWS_H_CTRL  = 8'h00;
  localparam logic [7:0]  TWS_H_ADDR  = 8'h04;
  localparam logic [7:0]  TWS_H_WDATA = 8'h08;
  localparam logic [7:0]  TWS_H_RDATA = 8'h0C;
  localparam logic [7:0]  TWS_H_STAT  = 8'h10;
  localparam int          TWS_GO_BIT  = 0;
  localparam int          TWS_RD_BIT  = 1;
  // ==========================================================
  // Timing
  localparam int TWS_SYS_HZ  = 100_000_000;
  localparam int TWS_SCL_HZ  = 400_000;
  localparam int TWS_QTR_CYC = TWS_SYS_HZ / (4 * TWS_SCL_HZ);
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    TWS_ST_IDLE, TWS_ST_RX, TWS_ST_RX_ACK, TWS_ST_TX, TWS_ST_TX_ACK
  } tws_state_e;
  typedef enum logic [2:0] {
    TWS_PH_ID, TWS_PH_AHI, TWS_PH_ALO, TWS_PH_DHI, TWS_PH_DLO
  } tws_phase_e;
  typedef enum logic [1:0] {
    TWS_K_START, TWS_K_SEND, TWS_K_RECV, TWS_K_STOP
  } tws_kind_e;
endpackage
`default_nettype wire

// ---- core/tws_link_if.sv ----
// Two-wire link between the bus master and the register slave
// Both lines are open drain with a pull-up; enables are active low
`default_nettype none
interface tws_link_if;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // ==========================================================
  // Wired-AND with pull-up
  assign scl = host_scl_oe_n | host_scl_out;
  assign sda = (host_sda_oe_n | host_sda_out)
             & (dev_sda_oe_n | dev_sda_out);
  modport host (output host_scl_out, host_scl_oe_n, host_sda_out,
                host_sda_oe_n, input scl, sda);
  modport dev  (output dev_sda_out, dev_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// ---- core/tws_dev.sv ----
// Register slave end of the two-wire control link
// Assumes link lines arrive asynchronously and the host owns the clock
`default_nettype none
// Notes on behaviour
// RULE1: Slave only; clock is an input
// RULE2: Ones are sent by releasing the line
// RULE3: First byte is identifier, LSB direction
// RULE4: Identifier 34h or 36h from select pin
// RULE5: Pull-down enable is bit 8 of 0721h
// RULE6: Start then eight identifier bits MSB first
// RULE7: Matching identifier gets an acknowledge
// RULE8: Mismatch gets no acknowledge, back idle
// RULE9: Stop returns the slave to idle
// RULE10: Stray start or stop abandons the transfer
// RULE11: Single and multiple reads and writes
// RULE12: Address advance only when 0101h bit 2
// RULE13: Pointer kept for reads from last address
// RULE14: Every register reads back
// RULE15: Works without core clock, synchronised with it
// RULE16: Write: two address bytes, then data words
// RULE17: Read: address, repeated start, then data out
module tws_dev #(
  parameter int          AW      = 4,
  parameter logic [15:0] CHIP_ID = 16'h5A5A  // Arbitrary value
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  tws_link_if.dev          link,
  input  wire logic        id_select_in,
  input  wire logic [15:0] pm_status_in,
  input  wire logic        core_system_clock_run_in,
  input  wire logic        core_system_clock_tick_in,
  output logic             id_select_pulldown_enable_out,
  output logic             auto_inc_out
);
  import tws_pkg::*;

  localparam int DEPTH = 2 ** AW;

  // ==========================================================
  // Register read decode
  function automatic logic [15:0] read_reg(
    input logic [15:0] a,
    input logic [15:0] m,
    input logic [15:0] cfg,
    input logic [15:0] pull,
    input logic [15:0] pm
  );
    logic [15:0] v;
    v = 16'h0000;
    if (a == TWS_CHIPID_ADDR) v = CHIP_ID;
    else if (a == TWS_PMSTAT_ADDR) v = pm;
    else if (a == TWS_CFG_ADDR) v = cfg;
    else if (a == TWS_PULL_ADDR) v = pull;
    else if (a < 16'(DEPTH)) v = m;
    return v;
  endfunction

  // ==========================================================
  // Line synchronisers
  logic [1:0]  scl_q;
  logic [1:0]  sda_q;
  logic [1:0]  sel_q;
  logic        scl_d;
  logic        sda_d;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      sel_q <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_q <= {scl_q[0], link.scl};
      sda_q <= {sda_q[0], link.sda};
      sel_q <= {sel_q[0], id_select_in};
      scl_d <= scl_q[1];
      sda_d <= sda_q[1];
    end
  end

  // ==========================================================
  // State and storage
  tws_state_e  st_r;
  tws_phase_e  ph_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic [7:0]  hi_r;
  logic [15:0] ptr_r;
  logic [15:0] word_r;
  logic        lo_sel_r;
  logic        rd_r;
  logic        mack_r;
  logic        sda_low_r;
  logic        wr_pend_r;
  logic [15:0] wr_addr_r;
  logic [15:0] wr_data_r;
  logic [15:0] cfg_r;
  logic [15:0] pull_r;
  logic [15:0] mem_r [DEPTH];

  // ==========================================================
  // Decode
  wire        scl_s     = scl_q[1];
  wire        sda_s     = sda_q[1];
  wire        scl_rise  = scl_s & ~scl_d;
  wire        scl_fall  = ~scl_s & scl_d;
  wire        start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire        stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0]  own_id    = sel_q[1] ? TWS_ID_HIGH : TWS_ID_LOW; // RULE4
  wire        id_hit    = sh_r[7:1] == own_id[7:1];
  wire [15:0] ptr_inc   = ptr_r
                        + {15'h0000, cfg_r[TWS_AUTO_INC_BIT]}; // RULE12
  wire [15:0] rd_cur    = read_reg(ptr_r, mem_r[ptr_r[AW-1:0]], cfg_r,
                                   pull_r, pm_status_in); // RULE14
  wire [15:0] rd_next   = read_reg(ptr_inc, mem_r[ptr_inc[AW-1:0]],
                                   cfg_r, pull_r, pm_status_in);
  wire [7:0]  tx_byte   = lo_sel_r ? word_r[7:0] : word_r[15:8];
  wire        commit    = wr_pend_r
                        & (~core_system_clock_run_in | core_system_clock_tick_in); // RULE15

  // ==========================================================
  // Serial protocol engine
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_r      <= TWS_ST_IDLE;
      ph_r      <= TWS_PH_ID;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      hi_r      <= 8'h00;
      ptr_r     <= 16'h0000;
      word_r    <= 16'h0000;
      lo_sel_r  <= 1'b0;
      rd_r      <= 1'b0;
      mack_r    <= 1'b0;
      sda_low_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 16'h0000;
      wr_data_r <= 16'h0000;
    end else begin
      if (commit) begin
        wr_pend_r <= 1'b0;
      end
      if (stop_det) begin
        st_r      <= TWS_ST_IDLE; // RULE9
        sda_low_r <= 1'b0; // RULE10
      end else if (start_det) begin
        st_r      <= TWS_ST_RX; // RULE6
        ph_r      <= TWS_PH_ID; // RULE10
        bit_r     <= 4'h0;
        sda_low_r <= 1'b0;
      end else begin
        case (st_r)
          TWS_ST_RX: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s}; // RULE6
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              bit_r <= 4'h0;
              if (ph_r == TWS_PH_ID && !id_hit) begin
                st_r <= TWS_ST_IDLE; // RULE8
              end else begin
                st_r      <= TWS_ST_RX_ACK;
                sda_low_r <= 1'b1; // RULE7
                case (ph_r)
                  TWS_PH_ID: begin
                    rd_r     <= sh_r[0]; // RULE3
                    ph_r     <= TWS_PH_AHI;
                    word_r   <= rd_cur; // RULE13
                    lo_sel_r <= 1'b0;
                  end
                  TWS_PH_AHI: begin
                    hi_r <= sh_r; // RULE16
                    ph_r <= TWS_PH_ALO;
                  end
                  TWS_PH_ALO: begin
                    ptr_r <= {hi_r, sh_r}; // RULE16
                    ph_r  <= TWS_PH_DHI;
                  end
                  TWS_PH_DHI: begin
                    hi_r <= sh_r;
                    ph_r <= TWS_PH_DLO;
                  end
                  default: begin
                    wr_pend_r <= 1'b1; // RULE11
                    wr_addr_r <= ptr_r;
                    wr_data_r <= {hi_r, sh_r};
                    ptr_r     <= ptr_inc; // RULE12
                    ph_r      <= TWS_PH_DHI;
                  end
                endcase
              end
            end
          end
          TWS_ST_RX_ACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (rd_r) begin
                st_r      <= TWS_ST_TX; // RULE17
                sda_low_r <= ~tx_byte[7]; // RULE2
              end else begin
                st_r      <= TWS_ST_RX;
                sda_low_r <= 1'b0;
              end
            end
          end
          TWS_ST_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h7) begin
                st_r      <= TWS_ST_TX_ACK;
                sda_low_r <= 1'b0;
              end else begin
                bit_r     <= bit_r + 4'h1;
                sda_low_r <= ~tx_byte[3'h6 - bit_r[2:0]]; // RULE2
              end
            end
          end
          TWS_ST_TX_ACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s;
              if (!sda_s) begin
                lo_sel_r <= ~lo_sel_r;
                if (lo_sel_r) begin
                  ptr_r  <= ptr_inc; // RULE11
                  word_r <= rd_next;
                end
              end
            end else if (scl_fall) begin
              bit_r <= 4'h0;
              if (mack_r) begin
                st_r      <= TWS_ST_TX;
                sda_low_r <= ~tx_byte[7];
              end else begin
                st_r <= TWS_ST_IDLE; // RULE17
              end
            end
          end
          default: begin
            sda_low_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register file
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cfg_r  <= TWS_CFG_RST;
      pull_r <= TWS_PULL_RST;
    end else if (commit) begin
      if (wr_addr_r == TWS_CFG_ADDR) cfg_r <= wr_data_r;
      if (wr_addr_r == TWS_PULL_ADDR) pull_r <= wr_data_r; // RULE5
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (commit && wr_addr_r < 16'(DEPTH)) begin
      mem_r[wr_addr_r[AW-1:0]] <= wr_data_r;
    end
  end

  // ==========================================================
  // Outputs
  assign link.dev_sda_out  = 1'b0; // RULE2
  assign link.dev_sda_oe_n = ~sda_low_r; // RULE1
  assign id_select_pulldown_enable_out = pull_r[TWS_PULL_PD_BIT]; // RULE5
  assign auto_inc_out = cfg_r[TWS_AUTO_INC_BIT];
endmodule
`default_nettype wire

// ---- core/tws_host.sv ----
// Bus master end of the two-wire control link
// Software orders one register write or read over AXI4-Lite
`default_nettype none
module tws_host #(
  parameter logic [7:0] DEV_ID  = 8'h34,
  parameter int         QTR_CYC = tws_pkg::TWS_QTR_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  tws_link_if.host         link,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);
  import tws_pkg::*;

  // ==========================================================
  // State
  logic [15:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic        busy_r;
  logic        nack_r;
  logic        rd_r;
  logic [15:0] div_r;
  logic [1:0]  q_r;
  logic [3:0]  step_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic        scl_low_r;
  logic        sda_low_r;
  logic [1:0]  sda_q;

  // ==========================================================
  // Sequence decode
  function automatic tws_kind_e kind_of(input logic [3:0] s,
                                        input logic rd);
    tws_kind_e k;
    k = TWS_K_SEND;
    if (s == 4'h0 || (rd && s == 4'h4)) k = TWS_K_START; // RULE17
    else if (rd && (s == 4'h6 || s == 4'h7)) k = TWS_K_RECV;
    else if (s == (rd ? 4'h8 : 4'h6)) k = TWS_K_STOP;
    return k;
  endfunction

  wire [3:0]  stop_step = rd_r ? 4'h8 : 4'h6;
  wire        qtick     = busy_r && div_r == 16'(QTR_CYC - 1);
  wire        aw_go     = s_axi_awvalid_in & s_axi_wvalid_in
                        & ~s_axi_awready_out & ~s_axi_bvalid_out;
  wire        ar_go     = s_axi_arvalid_in & ~s_axi_arready_out
                        & ~s_axi_rvalid_out;
  wire        go        = aw_go && s_axi_awaddr_in == TWS_H_CTRL
                        && s_axi_wdata_in[TWS_GO_BIT] && !busy_r;
  wire tws_kind_e kind  = kind_of(step_r, rd_r);
  wire [7:0]  tx_byte   = step_r == 4'h1 ? DEV_ID // RULE3
                        : step_r == 4'h2 ? addr_r[15:8] // RULE16
                        : step_r == 4'h3 ? addr_r[7:0]
                        : step_r == 4'h4 ? wdata_r[15:8]
                        : rd_r ? (DEV_ID | 8'h01) : wdata_r[7:0];
  wire        last_bit  = bit_r == 4'h8;
  wire [7:0]  rsel      = rd_r ? s_axi_araddr_in : s_axi_araddr_in;
  wire [15:0] rd_mux    = rsel == TWS_H_ADDR  ? addr_r
                        : rsel == TWS_H_WDATA ? wdata_r
                        : rsel == TWS_H_RDATA ? rdata_r
                        : rsel == TWS_H_STAT  ? {14'h0000, nack_r, busy_r}
                        : 16'h0000;

  // ==========================================================
  // AXI4-Lite slave
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      addr_r            <= 16'h0000;
      wdata_r           <= 16'h0000;
    end else begin
      s_axi_awready_out <= aw_go;
      s_axi_wready_out  <= aw_go;
      s_axi_arready_out <= ar_go;
      if (aw_go) begin
        s_axi_bvalid_out <= 1'b1;
        if (s_axi_awaddr_in == TWS_H_ADDR) addr_r <= s_axi_wdata_in[15:0];
        if (s_axi_awaddr_in == TWS_H_WDATA)
          wdata_r <= s_axi_wdata_in[15:0];
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      if (ar_go) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= {16'h0000, rd_mux};
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end
  assign s_axi_bresp_out = 2'h0;
  assign s_axi_rresp_out = 2'h0;

  // ==========================================================
  // Bit engine, four quarter ticks per bit
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sda_q     <= 2'h3;
      busy_r    <= 1'b0;
      nack_r    <= 1'b0;
      rd_r      <= 1'b0;
      div_r     <= 16'h0000;
      q_r       <= 2'h0;
      step_r    <= 4'h0;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      rdata_r   <= 16'h0000;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else begin
      sda_q <= {sda_q[0], link.sda};
      div_r <= qtick || !busy_r ? 16'h0000 : div_r + 16'h0001;
      if (go) begin
        busy_r <= 1'b1;
        nack_r <= 1'b0;
        rd_r   <= s_axi_wdata_in[TWS_RD_BIT];
        step_r <= 4'h0;
        q_r    <= 2'h0;
        bit_r  <= 4'h0;
      end else if (qtick) begin
        q_r <= q_r + 2'h1;
        case (kind)
          TWS_K_START: begin
            if (q_r == 2'h0) sda_low_r <= 1'b0;
            if (q_r == 2'h1) scl_low_r <= 1'b0;
            if (q_r == 2'h2) sda_low_r <= 1'b1; // RULE6
            if (q_r == 2'h3) begin
              scl_low_r <= 1'b1;
              step_r    <= step_r + 4'h1;
            end
          end
          TWS_K_STOP: begin
            if (q_r == 2'h0) sda_low_r <= 1'b1;
            if (q_r == 2'h1) scl_low_r <= 1'b0;
            if (q_r == 2'h2) sda_low_r <= 1'b0; // RULE9
            if (q_r == 2'h3) busy_r <= 1'b0;
          end
          default: begin
            if (q_r == 2'h0) begin
              if (kind == TWS_K_SEND)
                sda_low_r <= !last_bit && !tx_byte[3'h7 - bit_r[2:0]];
              else
                sda_low_r <= last_bit && step_r == 4'h6; // RULE17
            end
            if (q_r == 2'h1) scl_low_r <= 1'b0;
            if (q_r == 2'h2 && !last_bit) sh_r <= {sh_r[6:0], sda_q[1]};
            if (q_r == 2'h3) begin
              scl_low_r <= 1'b1;
              bit_r     <= last_bit ? 4'h0 : bit_r + 4'h1;
              if (last_bit) step_r <= step_r + 4'h1;
              if (last_bit && step_r == 4'h6) rdata_r[15:8] <= sh_r;
              if (last_bit && step_r == 4'h7) rdata_r[7:0] <= sh_r;
            end
            if (q_r == 2'h2 && last_bit && kind == TWS_K_SEND
                && sda_q[1]) begin
              nack_r <= 1'b1;
              step_r <= stop_step - 4'h1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Open-drain drive
  assign link.host_scl_out  = 1'b0;
  assign link.host_scl_oe_n = ~scl_low_r;
  assign link.host_sda_out  = 1'b0;
  assign link.host_sda_oe_n = ~sda_low_r; // RULE2
endmodule
`default_nettype wire

// ---- verif/tws_link_properties.sv ----
// Concurrent checks on the two-wire link between host and slave
// Assumes one clock domain with synchronous active-low reset
`default_nettype none
module tws_link_properties (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic host_scl_out,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Line events
  sequence s_start; scl && $past(scl) && $fell(sda); endsequence
  sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
  sequence s_quiet; dev_sda_oe_n [*8]; endsequence
  sequence s_drive; !dev_sda_oe_n [*8]; endsequence
  // ==========================================================
  // Properties
  property p_open_drain;
    !host_scl_out && !host_sda_out && !dev_sda_out
      && (!scl || dev_sda_oe_n || host_sda_oe_n);
  endproperty
  property p_reset_idle;
    $rose(rst_n_in) |-> dev_sda_oe_n && host_sda_oe_n && host_scl_oe_n;
  endproperty
  property p_change_scl_low;
    $changed(dev_sda_oe_n) |-> !scl && !$past(scl, 2);
  endproperty
  property p_no_stray;
    scl && $past(scl) |-> $stable(dev_sda_oe_n);
  endproperty
  property p_stop_idle;
    s_stop |=> s_quiet;
  endproperty
  property p_start_listen;
    s_start |=> s_quiet;
  endproperty
  property p_drive_hold;
    $fell(dev_sda_oe_n) |-> s_drive;
  endproperty
  property p_release_bound;
    $fell(dev_sda_oe_n) |-> ##[1:320] dev_sda_oe_n;
  endproperty
  // ==========================================================
  // Assertions
  a_open_drain: assert property (p_open_drain)
    else $error("link output driven high");
  a_reset_idle: assert property (p_reset_idle)
    else $error("line held after reset");
  a_change_scl_low: assert property (p_change_scl_low)
    else $error("slave data moved near clock high");
  a_no_stray: assert property (p_no_stray)
    else $error("slave data moved with clock high");
  a_stop_idle: assert property (p_stop_idle)
    else $error("slave drives after stop");
  a_start_listen: assert property (p_start_listen)
    else $error("slave drives during identifier");
  a_drive_hold: assert property (p_drive_hold)
    else $error("slave low bit not held");
  a_release_bound: assert property (p_release_bound)
    else $error("slave never releases data line");
endmodule
`default_nettype wire

// ---- verif/two_wire_register_slave_bench.sv ----
// Self-checking bench: AXI4-Lite orders, two-wire slave answers
// Assumes host and slave share one clock and the link interface
`default_nettype none
module two_wire_register_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tws_pkg::*;
  localparam logic [15:0] BENCH_CHIP = 16'hC3A5; // Arbitrary value
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        run        = 1'b0;
  logic        tick       = 1'b0;
  logic        id_sel     = 1'b0;
  logic [15:0] pm         = 16'h0000;
  logic [7:0]  awaddr     = 8'h00;
  logic [7:0]  araddr     = 8'h00;
  logic [31:0] wdata      = 32'h0000_0000;
  logic        awvalid    = 1'b0;
  logic        wvalid     = 1'b0;
  logic        bready     = 1'b0;
  logic        arvalid    = 1'b0;
  logic        rready     = 1'b0;
  logic        pd_en, auto_inc, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mdl [16];
  logic [15:0] cfg_m      = TWS_CFG_RST;
  logic [15:0] pull_m     = TWS_PULL_RST;
  int          fails      = 0;
  int          n_compared = 0;
  // ==========================================================
  // Design, link and checker
  tws_link_if link ();
  tws_dev #(.AW(4), .CHIP_ID(BENCH_CHIP)) u_tws_dev (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link),
    .id_select_in(id_sel), .pm_status_in(pm), .core_system_clock_run_in(run),
    .core_system_clock_tick_in(tick), .id_select_pulldown_enable_out(pd_en),
    .auto_inc_out(auto_inc));
  tws_host #(.DEV_ID(TWS_ID_LOW), .QTR_CYC(8)) u_tws_host (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  tws_link_properties u_tws_link_properties (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .host_scl_out(link.host_scl_out), .host_scl_oe_n(link.host_scl_oe_n),
    .host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n),
    .scl(link.scl), .sda(link.sda));
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) tick <= ($urandom_range(3) == 0);
  // ==========================================================
  // Expected register contents
  function automatic logic [15:0] exp_reg(input logic [15:0] a);
    if (a == TWS_CHIPID_ADDR) return BENCH_CHIP;
    if (a == TWS_PMSTAT_ADDR) return pm;
    if (a == TWS_CFG_ADDR) return cfg_m;
    if (a == TWS_PULL_ADDR) return pull_m;
    if (a < 16'h0010) return mdl[a[3:0]];
    return 16'h0000;
  endfunction
  task automatic mdl_wr(input logic [15:0] a, input logic [15:0] d);
    if (a == TWS_CFG_ADDR) cfg_m = d;
    else if (a == TWS_PULL_ADDR) pull_m = d;
    else if (a < 16'h0010) mdl[a[3:0]] = d;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ==========================================================
  // Bus tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    @(posedge sys_clk_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      done = (bvalid === 1'b1);
    end
    chk("bresp", 32'h0000_0000, 32'(bresp));
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] r);
    logic done;
    @(posedge sys_clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge sys_clk_in);
      if (arready === 1'b1) arvalid <= 1'b0;
      done = (rvalid === 1'b1);
      r = rdata;
    end
    chk("rresp", 32'h0000_0000, 32'(rresp));
    rready <= 1'b0;
  endtask
  task automatic dev_op(input logic rd, input logic [15:0] a,
                        input logic [15:0] d, output logic [31:0] r);
    int n;
    axi_wr(TWS_H_ADDR, {16'h0000, a});
    axi_wr(TWS_H_WDATA, {16'h0000, d});
    axi_wr(TWS_H_CTRL, {30'h0, rd, 1'b1});
    n = 0;
    r = 32'h0000_0001;
    while (r[0] !== 1'b0 && n < 3000) begin
      axi_rd(TWS_H_STAT, r);
      n++;
    end
    if (n == 3000) chk("busy_clear", 32'h0000_0000, r);
    if (rd) axi_rd(TWS_H_RDATA, r);
  endtask
  task automatic results();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (95000) @(posedge sys_clk_in);
    fails++;
    results();
  end
  initial begin
    logic [15:0] ad [6];
    logic [15:0] d;
    logic [31:0] r;
    void'($urandom(99894));
    pm <= 16'($urandom);
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    dev_op(1'b1, TWS_CFG_ADDR, 16'h0000, r);
    chk("cfg_reset", {16'h0000, TWS_CFG_RST}, r);
    dev_op(1'b1, TWS_PULL_ADDR, 16'h0000, r);
    chk("pull_reset", {16'h0000, TWS_PULL_RST}, r);
    for (int k = 0; k < 3; k++) begin
      ad = '{TWS_CHIPID_ADDR, TWS_PMSTAT_ADDR, TWS_CFG_ADDR,
             TWS_PULL_ADDR, 16'h0200, 16'($urandom_range(15, 3))};
      foreach (ad[i]) begin
        d = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'($urandom);
        run <= (i % 2 == 0);
        dev_op(1'b0, ad[i], d, r);
        mdl_wr(ad[i], d);
        dev_op(1'b1, ad[i], 16'h0000, r);
        chk("reg_read", {16'h0000, exp_reg(ad[i])}, r);
      end
      chk("auto_inc", 32'(cfg_m[TWS_AUTO_INC_BIT]), 32'(auto_inc));
      chk("pulldown", 32'(pull_m[TWS_PULL_PD_BIT]), 32'(pd_en));
    end
    dev_op(1'b0, 16'h0005, 16'h1357, r);
    mdl_wr(16'h0005, 16'h1357);
    id_sel <= 1'b1;
    dev_op(1'b0, 16'h0005, 16'hBEEF, r);
    axi_rd(TWS_H_STAT, r);
    chk("nack", 32'h0000_0002, r);
    id_sel <= 1'b0;
    dev_op(1'b1, 16'h0005, 16'h0000, r);
    chk("reg_kept", {16'h0000, exp_reg(16'h0005)}, r);
    axi_rd(TWS_H_STAT, r);
    chk("nack_clear", 32'h0000_0000, r);
    axi_rd(8'h20, r);
    chk("host_unmapped", 32'h0000_0000, r);
    results();
  end
endmodule
`default_nettype wire
